// *** verilog/pllfd_pkg.sv ***
// Package for the PLL reference and feedback divider block
package pllfd_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_REF_LO = 8'h00;
  localparam logic [7:0] ADDR_REF_HI = 8'h04;
  localparam logic [7:0] ADDR_SWAL   = 8'h08;
  localparam logic [7:0] ADDR_MAIN_LO = 8'h0c;
  localparam logic [7:0] ADDR_MAIN_HI = 8'h10;
  localparam logic [7:0] ADDR_PRESC  = 8'h14;
  localparam logic [7:0] ADDR_CTRL   = 8'h18;
  localparam logic [7:0] ADDR_DELAY  = 8'h1c;
  localparam logic [7:0] ADDR_STATUS = 8'h20;

  // Documented widths
  localparam int REF_W  = 14;
  localparam int MAIN_W = 13;
  localparam int SWAL_W = 6;
  localparam int PRE_W  = 6;
  localparam int BYTE_W = 8;

  // Control register fields
  localparam int CTRL_REF_RST  = 0;
  localparam int CTRL_AB_RST   = 1;
  localparam int CTRL_ALL_RST  = 2;
  localparam int CTRL_SYNC_LO  = 6;
  localparam int CTRL_SYNC_HI  = 7;
  localparam logic [1:0] SYNC_OFF = 2'h0;

  // Delay register fields
  localparam int DLY_REF_LO = 0;
  localparam int DLY_REF_EN = 3;
  localparam int DLY_FB_LO  = 4;
  localparam int DLY_FB_EN  = 7;
  localparam int DLY_CODE_W = 3;

  // Status register fields
  localparam int STAT_SWAL  = 0;
  localparam int STAT_SYNC  = 1;
  localparam int STAT_MAIN_LO = 16;

  // Prescaler mode codes
  localparam logic [2:0] MODE_DM2  = 3'h0;
  localparam logic [2:0] MODE_DM4  = 3'h1;
  localparam logic [2:0] MODE_DM8  = 3'h2;
  localparam logic [2:0] MODE_DM16 = 3'h3;
  localparam logic [2:0] MODE_DM32 = 3'h4;
  localparam logic [2:0] MODE_FD1  = 3'h5;
  localparam logic [2:0] MODE_FD2  = 3'h6;
  localparam logic [2:0] MODE_FD3  = 3'h7;
  localparam logic [PRE_W-1:0] PRE_ONE = 6'h01;

  // Reset values
  localparam logic [REF_W-1:0]  REF_RST_VAL  = 14'h0001;
  localparam logic [SWAL_W-1:0] SWAL_RST_VAL = 6'h00;
  localparam logic [MAIN_W-1:0] MAIN_RST_VAL = 13'h0003;
  localparam logic [2:0]        MODE_RST_VAL = MODE_DM2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [REF_W-1:0]  ref_div;
    logic [SWAL_W-1:0] swallow;
    logic [MAIN_W-1:0] main_div;
    logic [2:0]        mode;
  } pllfd_cfg_type;

  typedef struct packed {
    logic                  enable;
    logic [DLY_CODE_W-1:0] code;
  } pllfd_dly_type;
endpackage

// *** verilog/pllfd_div.sv ***
// Programmable modulo counter used by every divider stage
`timescale 1ns/10ps
`default_nettype none
module pllfd_div #(
  parameter int W = 14
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // Counting
  input  wire logic         clr,
  input  wire logic         tick,
  input  wire logic [W-1:0] modulus,
  output logic      [W-1:0] count,
  output logic              wrap
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic [W-1:0] last;

  if (W < 2) $error("pllfd_div: W must be at least 2");

  // Modulus 0 acts as 1; >= keeps a lowered modulus from overrunning
  always_comb
  begin
    last  = (modulus == '0) ? '0 : modulus - W'(1);
    wrap  = tick && !clr && (cnt_q >= last);
    cnt_d = cnt_q;
    if (clr)
    begin
      cnt_d = '0;
    end
    else if (tick)
    begin
      cnt_d = wrap ? '0 : cnt_q + W'(1);
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
    end
    else if (ce)
    begin
      cnt_q <= cnt_d;
    end
  end

  assign count = cnt_q;
endmodule
`default_nettype wire

// *** verilog/pllfd_top.sv ***
// PLL reference divider, prescaler, swallow and main counters with AXI4-Lite registers
//
// Chosen here: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module pllfd_top
  import pllfd_pkg::*;
#(
  parameter int REF_BITS  = pllfd_pkg::REF_W,
  parameter int MAIN_BITS = pllfd_pkg::MAIN_W
) (
  // Clock, reset, enable
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    ce,
  // Divider inputs, one-cycle pulses per edge; sync_pin_n is an active-low level
  input  wire logic                    ref_tick,
  input  wire logic                    vco_tick,
  input  wire logic                    sync_pin_n,
  // Phase detector inputs and delay cell settings
  output logic                         pd_ref_q,
  output logic                         pd_fb_q,
  output pllfd_pkg::pllfd_dly_type     ref_dly_q,
  output pllfd_pkg::pllfd_dly_type     fb_dly_q,
  // AXI4-Lite slave
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready
);
  import pllfd_pkg::*;

  if (REF_BITS != REF_W || MAIN_BITS != MAIN_W)
    $error("pllfd_top: register layout serves only the documented widths");

  // Reset release
  logic rst_m_q;
  logic rst_s_q;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end
    else
    begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // Register write path
  pllfd_cfg_type cfg_q, cfg_d;
  logic [7:0]    ctrl_q, ctrl_d;
  logic [7:0]    dly_q, dly_d;
  logic          aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0]    aw_addr_q, aw_addr_d;
  logic [7:0]    w_byte_q, w_byte_d;
  logic          w_lane_q, w_lane_d;
  logic          awready_d, wready_d, bvalid_d;
  logic [1:0]    bresp_d;

  always_comb
  begin
    cfg_d     = cfg_q;
    ctrl_d    = ctrl_q;
    dly_d     = dly_q;
    aw_have_d = aw_have_q;
    w_have_d  = w_have_q;
    aw_addr_d = aw_addr_q;
    w_byte_d  = w_byte_q;
    w_lane_d  = w_lane_q;
    bvalid_d  = s_axi_bvalid && !s_axi_bready;
    bresp_d   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_d = 1'b1;
      w_byte_d = s_axi_wdata[BYTE_W-1:0];
      w_lane_d = s_axi_wstrb[0];
    end
    if (aw_have_q && w_have_q)
    begin
      aw_have_d = 1'b0;
      w_have_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      unique case (aw_addr_q)
        ADDR_REF_LO:  if (w_lane_q) cfg_d.ref_div[BYTE_W-1:0] = w_byte_q;
        ADDR_REF_HI:  if (w_lane_q) cfg_d.ref_div[REF_W-1:BYTE_W] = w_byte_q[REF_W-BYTE_W-1:0];
        ADDR_SWAL:    if (w_lane_q) cfg_d.swallow = w_byte_q[SWAL_W-1:0];
        ADDR_MAIN_LO: if (w_lane_q) cfg_d.main_div[BYTE_W-1:0] = w_byte_q;
        ADDR_MAIN_HI: if (w_lane_q) cfg_d.main_div[MAIN_W-1:BYTE_W] = w_byte_q[MAIN_W-BYTE_W-1:0];
        ADDR_PRESC:   if (w_lane_q) cfg_d.mode = w_byte_q[2:0];
        ADDR_CTRL:    if (w_lane_q) ctrl_d = w_byte_q;
        ADDR_DELAY:   if (w_lane_q) dly_d = w_byte_q;
        ADDR_STATUS:  bresp_d = RESP_OKAY;
        default:      bresp_d = RESP_SLVERR;
      endcase
    end
    // One write in flight; hold off new halves until the answer is taken
    awready_d = !aw_have_d && !bvalid_d;
    wready_d  = !w_have_d && !bvalid_d;
  end

  always_ff @(posedge clock or negedge rst_s_q)
  begin
    if (!rst_s_q)
    begin
      cfg_q         <= '{ref_div: REF_RST_VAL, swallow: SWAL_RST_VAL,
                         main_div: MAIN_RST_VAL, mode: MODE_RST_VAL};
      ctrl_q        <= '0;
      dly_q         <= '0;
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      aw_addr_q     <= '0;
      w_byte_q      <= '0;
      w_lane_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else if (ce)
    begin
      cfg_q         <= cfg_d;
      ctrl_q        <= ctrl_d;
      dly_q         <= dly_d;
      aw_have_q     <= aw_have_d;
      w_have_q      <= w_have_d;
      aw_addr_q     <= aw_addr_d;
      w_byte_q      <= w_byte_d;
      w_lane_q      <= w_lane_d;
      s_axi_awready <= awready_d;
      s_axi_wready  <= wready_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_bresp   <= bresp_d;
    end
  end

  // Divider chain
  logic              sync_rst, ref_rst, ab_rst, fixed_mode, swal_phase;
  logic [PRE_W-1:0]  pre_mod, pre_cnt;
  logic [REF_W-1:0]  ref_cnt;
  logic [MAIN_W-1:0] main_cnt;
  logic              ref_wrap, pre_wrap, main_wrap;

  always_comb
  begin
    sync_rst = (ctrl_q[CTRL_SYNC_HI:CTRL_SYNC_LO] != SYNC_OFF) && !sync_pin_n;
    ref_rst  = ctrl_q[CTRL_REF_RST] || ctrl_q[CTRL_ALL_RST] || sync_rst;
    ab_rst   = ctrl_q[CTRL_AB_RST] || ctrl_q[CTRL_ALL_RST] || sync_rst;
    fixed_mode = (cfg_q.mode == MODE_FD1) || (cfg_q.mode == MODE_FD2)
                 || (cfg_q.mode == MODE_FD3);
    // Swallow zero means no P+1 cycles at all
    swal_phase = !fixed_mode && (main_cnt < MAIN_W'(cfg_q.swallow));
    unique case (cfg_q.mode)
      MODE_FD1: pre_mod = PRE_ONE;
      MODE_FD2: pre_mod = PRE_W'(2);
      MODE_FD3: pre_mod = PRE_W'(3);
      default:  pre_mod = (PRE_ONE << (cfg_q.mode + 3'h1)) + PRE_W'(swal_phase);
    endcase
  end

  // Settings 0 and 1 both give a wrap on every reference edge
  pllfd_div #(.W(REF_W)) u_ref_div (
    .clock   (clock),
    .rst_n   (rst_s_q),
    .ce      (ce),
    .clr     (ref_rst),
    .tick    (ref_tick),
    .modulus (cfg_q.ref_div),
    .count   (ref_cnt),
    .wrap    (ref_wrap)
  );

  pllfd_div #(.W(PRE_W)) u_presc (
    .clock   (clock),
    .rst_n   (rst_s_q),
    .ce      (ce),
    .clr     (ab_rst),
    .tick    (vco_tick),
    .modulus (pre_mod),
    .count   (pre_cnt),
    .wrap    (pre_wrap)
  );

  // Main value 1 passes every prescaler cycle straight out
  pllfd_div #(.W(MAIN_W)) u_main (
    .clock   (clock),
    .rst_n   (rst_s_q),
    .ce      (ce),
    .clr     (ab_rst),
    .tick    (pre_wrap),
    .modulus (cfg_q.main_div),
    .count   (main_cnt),
    .wrap    (main_wrap)
  );

  // Registered outputs and read path
  logic        arready_d, rvalid_d;
  logic [31:0] rdata_d;
  logic [1:0]  rresp_d;

  always_comb
  begin
    rvalid_d = s_axi_rvalid && !s_axi_rready;
    rdata_d  = s_axi_rdata;
    rresp_d  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rdata_d  = '0;
      rresp_d  = RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_REF_LO:  rdata_d[BYTE_W-1:0] = cfg_q.ref_div[BYTE_W-1:0];
        ADDR_REF_HI:  rdata_d[REF_W-BYTE_W-1:0] = cfg_q.ref_div[REF_W-1:BYTE_W];
        ADDR_SWAL:    rdata_d[SWAL_W-1:0] = cfg_q.swallow;
        ADDR_MAIN_LO: rdata_d[BYTE_W-1:0] = cfg_q.main_div[BYTE_W-1:0];
        ADDR_MAIN_HI: rdata_d[MAIN_W-BYTE_W-1:0] = cfg_q.main_div[MAIN_W-1:BYTE_W];
        ADDR_PRESC:   rdata_d[2:0] = cfg_q.mode;
        ADDR_CTRL:    rdata_d[BYTE_W-1:0] = ctrl_q;
        ADDR_DELAY:   rdata_d[BYTE_W-1:0] = dly_q;
        ADDR_STATUS:
        begin
          rdata_d[STAT_SWAL] = swal_phase;
          rdata_d[STAT_SYNC] = sync_rst;
          rdata_d[STAT_MAIN_LO +: MAIN_W] = main_cnt;
        end
        default:      rresp_d = RESP_SLVERR;
      endcase
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge clock or negedge rst_s_q)
  begin
    if (!rst_s_q)
    begin
      pd_ref_q      <= 1'b0;
      pd_fb_q       <= 1'b0;
      ref_dly_q     <= '0;
      fb_dly_q      <= '0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (ce)
    begin
      pd_ref_q      <= ref_wrap;
      pd_fb_q       <= main_wrap;
      ref_dly_q     <= '{enable: dly_d[DLY_REF_EN], code: dly_d[DLY_REF_LO +: DLY_CODE_W]};
      fb_dly_q      <= '{enable: dly_d[DLY_FB_EN], code: dly_d[DLY_FB_LO +: DLY_CODE_W]};
      s_axi_arready <= arready_d;
      s_axi_rvalid  <= rvalid_d;
      s_axi_rdata   <= rdata_d;
      s_axi_rresp   <= rresp_d;
    end
  end

  // Checks
  sequence s_ref_edge_unity;
    ce && ref_tick && !ref_rst && (cfg_q.ref_div <= REF_W'(1));
  endsequence
  sequence s_fb_bypass;
    ce && pre_wrap && !ab_rst && (cfg_q.main_div <= MAIN_W'(1));
  endsequence

  ref_unity_a: assert property (@(posedge clock) disable iff (!rst_s_q)
    s_ref_edge_unity |=> pd_ref_q) else $error("ref divide by one missed");
  ref_reset_a: assert property (@(posedge clock) disable iff (!rst_s_q)
    ce && ref_rst |=> (ref_cnt == '0) && !pd_ref_q) else $error("ref reset ignored");
  sync_pin_a: assert property (@(posedge clock) disable iff (!rst_s_q)
    ce && sync_rst |=> (ref_cnt == '0) && (main_cnt == '0) && (pre_cnt == '0))
    else $error("sync pin reset ignored");
  fixed_mode_a: assert property (@(posedge clock) disable iff (!rst_s_q)
    fixed_mode |-> (pre_mod <= PRE_W'(3)) && !swal_phase) else $error("fixed mode used swallow");
  swallow_phase_a: assert property (@(posedge clock) disable iff (!rst_s_q)
    !fixed_mode && (main_cnt < MAIN_W'(cfg_q.swallow))
    |-> pre_mod == (PRE_ONE << (cfg_q.mode + 3'h1)) + PRE_ONE)
    else $error("prescaler not at P+1 in swallow phase");
  plain_phase_a: assert property (@(posedge clock) disable iff (!rst_s_q)
    !fixed_mode && (main_cnt >= MAIN_W'(cfg_q.swallow))
    |-> pre_mod == (PRE_ONE << (cfg_q.mode + 3'h1))) else $error("prescaler not at P");
  fb_bypass_a: assert property (@(posedge clock) disable iff (!rst_s_q)
    s_fb_bypass |=> pd_fb_q) else $error("bypassed main counter held pulse");
  fb_source_a: assert property (@(posedge clock) disable iff (!rst_s_q)
    ce && $rose(pd_fb_q) |-> $past(pre_wrap)) else $error("feedback pulse without prescaler");
  sync_default_a: assert property (@(posedge clock)
    $rose(rst_s_q) |-> ctrl_q[CTRL_SYNC_HI:CTRL_SYNC_LO] == SYNC_OFF)
    else $error("sync pin reset enabled after reset");
endmodule
`default_nettype wire

// *** bench/pllfd_bench.sv ***
// Self-checking bench for the PLL reference and feedback divider block
`timescale 1ns/10ps
`default_nettype none
module pllfd_bench;
  import pllfd_pkg::*;
  logic          clock = 1'b0;
  logic          rst_n = 1'b0;
  logic          ce = 1'b1;
  logic          ref_tick = 1'b0;
  logic          vco_tick = 1'b0;
  logic          sync_pin_n = 1'b1;
  logic          pd_ref_q;
  logic          pd_fb_q;
  pllfd_dly_type ref_dly_q;
  pllfd_dly_type fb_dly_q;
  logic [7:0]    aw_addr = 8'h00;
  logic          aw_valid = 1'b0;
  logic          aw_ready;
  logic [31:0]   w_data = 32'h0;
  logic [3:0]    w_strb = 4'h0;
  logic          w_valid = 1'b0;
  logic          w_ready;
  logic [1:0]    b_resp;
  logic          b_valid;
  logic          b_ready = 1'b0;
  logic [7:0]    ar_addr = 8'h00;
  logic          ar_valid = 1'b0;
  logic          ar_ready;
  logic [31:0]   r_data;
  logic [1:0]    r_resp;
  logic          r_valid;
  logic          r_ready = 1'b0;
  int            n_errors = 0;
  int            n_checks = 0;
  int            cycles = 0;
  int            n_ref = 0;
  int            n_fb = 0;
  int            ref_cnt = 0;
  int            fb_cnt = 0;
  int            exp_r = 1;
  int            exp_f = 1;
  bit            measure = 1'b0;
  bit            ticking = 1'b0;
  logic [15:0]   lfsr = 16'h003a;
  logic [31:0]   rd;
  logic [1:0]    rsp;
  int            rs[10] = '{0, 1, 3, 2, 7, 5, 10, 1, 16383, 4};
  int            ms[10] = '{5, 6, 0, 1, 2, 3, 4, 0, 7, 2};
  int            as[10] = '{0, 5, 1, 0, 7, 7, 6, 2, 0, 0};
  int            bs[10] = '{1, 3, 3, 3, 18, 9, 47, 300, 3, 1};
  // Fields: ctrl, sync level, ce, ref active, feedback active
  logic [11:0]   hv[7] = '{12'h01d, 12'h02e, 12'h04c, 12'h007, 12'h404, 12'hc0f, 12'h008};

  pllfd_top pllfd_top_inst (
    .clock(clock), .rst_n(rst_n), .ce(ce), .ref_tick(ref_tick), .vco_tick(vco_tick),
    .sync_pin_n(sync_pin_n), .pd_ref_q(pd_ref_q), .pd_fb_q(pd_fb_q),
    .ref_dly_q(ref_dly_q), .fb_dly_q(fb_dly_q),
    .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid), .s_axi_awready(aw_ready),
    .s_axi_wdata(w_data), .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid),
    .s_axi_wready(w_ready), .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid),
    .s_axi_bready(b_ready), .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_valid),
    .s_axi_arready(ar_ready), .s_axi_rdata(r_data), .s_axi_rresp(r_resp),
    .s_axi_rvalid(r_valid), .s_axi_rready(r_ready)
  );

  always #12.5 clock = ~clock;

  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  task automatic summarize();
    if (n_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Random tick density keeps gaps between divider inputs
  always @(posedge clock)
  begin
    lfsr = lfsr_next(lfsr);
    ref_tick <= ticking && (lfsr[2:0] != 3'h0);
    vco_tick <= ticking && (lfsr[5:3] != 3'h0);
  end

  // Ceiling well above the longest reference case
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      n_errors++;
      summarize();
    end
  end

  // Period model: ticks counted between output pulses
  always @(posedge clock)
  begin
    if (pd_ref_q === 1'b1)
    begin
      n_ref++;
      if (measure && n_ref > 1)
        check(ref_cnt, exp_r);
      ref_cnt = int'(ref_tick);
    end
    else
      ref_cnt += int'(ref_tick);
    if (pd_fb_q === 1'b1)
    begin
      n_fb++;
      if (measure && n_fb > 1)
        check(fb_cnt, exp_f);
      fb_cnt = int'(vco_tick);
    end
    else
      fb_cnt += int'(vco_tick);
  end

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    bit aw_done;
    bit w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clock);
    aw_addr <= a;
    w_data <= d;
    w_strb <= s;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (!aw_done && aw_ready === 1'b1)
      begin
        aw_done = 1'b1;
        aw_valid <= 1'b0;
      end
      if (!w_done && w_ready === 1'b1)
      begin
        w_done = 1'b1;
        w_valid <= 1'b0;
      end
    end while (b_valid !== 1'b1);
    r = b_resp;
    b_ready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ar_done;
    ar_done = 1'b0;
    @(posedge clock);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    do
    begin
      @(posedge clock);
      if (!ar_done && ar_ready === 1'b1)
      begin
        ar_done = 1'b1;
        ar_valid <= 1'b0;
      end
    end while (r_valid !== 1'b1);
    d = r_data;
    r = r_resp;
    r_ready <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, 4'hf, r);
    check({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check(d, e);
    check({30'h0, r}, {30'h0, RESP_OKAY});
  endtask

  // Counters held in shared reset while the new setting goes in
  task automatic run_case(input int r, input int m, input int a, input int b);
    logic [13:0] rv;
    logic [12:0] bv;
    rv = 14'(r);
    bv = 13'(b);
    wr(ADDR_CTRL, 32'h4);
    wr(ADDR_REF_LO, {24'h0, rv[7:0]});
    wr(ADDR_REF_HI, {26'h0, rv[13:8]});
    wr(ADDR_SWAL, 32'(a));
    wr(ADDR_MAIN_LO, {24'h0, bv[7:0]});
    wr(ADDR_MAIN_HI, {27'h0, bv[12:8]});
    wr(ADDR_PRESC, 32'(m));
    exp_r = (r < 2) ? 1 : r;
    exp_f = (m >= 5) ? (m - 4) * b : (2 << m) * b + a;
    wr(ADDR_CTRL, 32'h0);
    @(negedge clock);
    n_ref = 0;
    n_fb = 0;
    measure = 1'b1;
    while (n_ref < 2 || n_fb < 2)
      @(posedge clock);
    measure <= 1'b0;
  endtask

  // Ticks paused first so no pulse is frozen high by ce
  task automatic hold(input logic [7:0] c, input logic s, input logic e, input logic er,
                      input logic ef);
    logic [31:0] d;
    logic [1:0]  r;
    wr(ADDR_CTRL, {24'h0, c});
    rd_chk(ADDR_CTRL, {24'h0, c});
    ticking <= 1'b0;
    repeat (4) @(posedge clock);
    sync_pin_n <= s;
    ce <= e;
    @(negedge clock);
    n_ref = 0;
    n_fb = 0;
    ticking = 1'b1;
    repeat (60) @(posedge clock);
    check((n_ref > 0) ? 32'h1 : 32'h0, {31'h0, er});
    check((n_fb > 0) ? 32'h1 : 32'h0, {31'h0, ef});
    ce <= 1'b1;
    // Status read while the pin still holds its level
    axi_read(ADDR_STATUS, d, r);
    check({31'h0, d[STAT_SYNC]}, {31'h0, (c[CTRL_SYNC_HI:CTRL_SYNC_LO] != SYNC_OFF) && !s});
    check({30'h0, r}, {30'h0, RESP_OKAY});
    sync_pin_n <= 1'b1;
    wr(ADDR_CTRL, 32'h0);
  endtask

  initial
  begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (6) @(posedge clock);
    for (int i = 0; i < 8; i++)
      rd_chk(8'(4 * i), (i == 0) ? 32'h1 : (i == 3) ? 32'h3 : 32'h0);
    wr(ADDR_DELAY, 32'ha5);
    repeat (2) @(posedge clock);
    check({28'h0, ref_dly_q}, 32'h5);
    check({28'h0, fb_dly_q}, 32'ha);
    axi_write(ADDR_DELAY, 32'h3c, 4'he, rsp);
    check({30'h0, rsp}, {30'h0, RESP_OKAY});
    rd_chk(ADDR_DELAY, 32'ha5);
    wr(ADDR_REF_HI, 32'hff);
    rd_chk(ADDR_REF_HI, 32'h3f);
    wr(ADDR_PRESC, 32'hff);
    rd_chk(ADDR_PRESC, 32'h7);
    wr(ADDR_STATUS, 32'h3);
    axi_write(8'h24, 32'h1, 4'hf, rsp);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    axi_read(8'h24, rd, rsp);
    check(rd, 32'h0);
    check({30'h0, rsp}, {30'h0, RESP_SLVERR});
    ticking <= 1'b1;
    for (int i = 0; i < 10; i++)
      run_case(rs[i], ms[i], as[i], bs[i]);
    for (int i = 0; i < 7; i++)
      hold(hv[i][11:4], hv[i][3], hv[i][2], hv[i][1], hv[i][0]);
    summarize();
  end
endmodule
`default_nettype wire
